// ---- hw/dds_top.sv ----
// Purpose: digital control of a dual 12-bit voltage-output converter
// Assumes: host drives frame strobe, serial clock and data; apb on pclk
// Notes: link logic runs on the serial clock, decode logic on pclk
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dds_top
#(
   parameter int unsigned FRAME_CNT_W = 16 // width of executed-frame counter
)
(
   // apb slave, pclk domain
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dds_pkg::DDS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link, serial clock domain
   input wire logic serial_clk,
   input wire logic frame_strobe_n,
   input wire logic serial_data,
   // converter side, pclk domain
   output logic [dds_pkg::DDS_CODE_W-1:0] channel_a_output_code,
   output logic [dds_pkg::DDS_CODE_W-1:0] channel_b_output_code,
   output logic powered_down,
   output logic [1:0] termination
);
   import dds_pkg::*;

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   // link domain
   logic link_rst_n; // frame reset: low between frames or on reset
   logic [4:0] bit_cnt_ff; // falling edges seen in this frame
   logic [DDS_WORD_W-2:0] shift_ff; // bits shifted in so far
   logic [DDS_WORD_W-1:0] frame_word_ff; // last complete command word
   logic frame_tgl_ff; // flips once per complete frame

   // pclk domain crossing
   logic tgl_s1_ff; // first stage, read only by the second
   logic tgl_s2_ff; // second stage
   logic tgl_s3_ff; // previous value for edge detect
   logic frame_arrived; // one pclk pulse per complete frame
   logic frame_exec; // frame arrived and accepted

   // decoded fields of the captured word
   logic sel_b; // channel select, high for channel b
   dds_mode_t mode; // operating mode
   logic [DDS_CODE_W-1:0] code; // twelve-bit code
   dds_term_t nxt_term; // termination picked by lead bits

   // converter state
   logic [DDS_CODE_W-1:0] hold_ff [2]; // holding register per channel
   logic [DDS_CODE_W-1:0] out_ff [2]; // output register per channel
   logic powered_down_ff; // both channels powered down
   dds_term_t term_ff; // termination in force while powered down
   logic ever_valid_ff; // at least one frame executed
   logic [FRAME_CNT_W-1:0] frame_cnt_ff; // frames executed
   logic [DDS_WORD_W-1:0] last_word_ff; // copy of last executed word

   // apb
   logic accept_ff; // software enable for frame execution
   logic [31:0] prdata_ff; // read data register
   logic pready_ff; // answer strobe, one cycle per transfer
   logic pslverr_ff; // unmapped address answer
   logic apb_setup; // setup phase of a transfer
   logic apb_wr; // write takes effect this edge
   logic [31:0] nxt_rdata; // read mux result
   logic nxt_err; // address not mapped

   // -------------------------------------------------------------------
   // serial link (serial clock domain)
   // -------------------------------------------------------------------
   // strobe high clears the bit count asynchronously, so a frame cut
   // short leaves nothing behind and nothing is taken between frames
   assign link_rst_n = presetn & ~frame_strobe_n;

   // count falling edges, stopping at sixteen
   always_ff @(negedge serial_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         bit_cnt_ff <= DDS_CNT_RST;
      end
      else if (bit_cnt_ff != DDS_FRAME_DONE)
      begin
         // further edges leave the count at sixteen
         bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
   end

   // shift data in, msb first, on the first fifteen falling edges of the frame
   always_ff @(negedge serial_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         shift_ff <= '0;
      end
      else if (bit_cnt_ff < DDS_FRAME_LAST)
      begin
         shift_ff <= {shift_ff[DDS_WORD_W-3:0], serial_data};
      end
   end

   // the sixteenth edge completes the word and flags it across
   always_ff @(negedge serial_clk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_word_ff <= DDS_WORD_RST;
         frame_tgl_ff <= 1'b0;
      end
      else if (link_rst_n && bit_cnt_ff == DDS_FRAME_LAST)
      begin
         // final bit joins the word; word held until next full frame
         frame_word_ff <= {shift_ff, serial_data};
         frame_tgl_ff <= ~frame_tgl_ff;
      end
   end

   // -------------------------------------------------------------------
   // frame crossing into pclk domain
   // -------------------------------------------------------------------
   // toggle passes two flops, a third detects the change; the word is
   // stable for sixteen serial clocks after the toggle, far longer than
   // the three pclk cycles needed before it is read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tgl_s1_ff <= 1'b0;
         tgl_s2_ff <= 1'b0;
         tgl_s3_ff <= 1'b0;
      end
      else
      begin
         tgl_s1_ff <= frame_tgl_ff;
         tgl_s2_ff <= tgl_s1_ff;
         tgl_s3_ff <= tgl_s2_ff;
      end
   end

   assign frame_arrived = tgl_s2_ff ^ tgl_s3_ff;
   assign frame_exec = frame_arrived & accept_ff;

   // -------------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------------
   // second bit addresses the channel
   assign sel_b = frame_word_ff[DDS_BIT_LEAD_LOW];
   // next two bits give the mode
   assign mode = dds_mode_t'(
      frame_word_ff[DDS_BIT_MODE_HIGH:DDS_BIT_MODE_LOW]);
   // (mode encoding in dds_pkg)
   // remaining twelve bits, straight binary
   assign code = frame_word_ff[DDS_CODE_MSB:0];

   // lead bits choose the termination in power-down
   always_comb
   begin
      case (frame_word_ff[DDS_BIT_LEAD_HIGH:DDS_BIT_LEAD_LOW])
         2'h1: nxt_term = dds_term_2k5_gnd;
         2'h2: nxt_term = dds_term_100k_gnd;
         default: nxt_term = dds_term_high_z; // 00 and 11
      endcase
   end

   // -------------------------------------------------------------------
   // channel registers, one generate instance per channel
   // -------------------------------------------------------------------
   generate
      for (genvar ch = 0; ch < 2; ch++)
      begin : g_chan
         localparam logic CH_B = (ch == 1) ? 1'b1 : 1'b0;

         // holding register loads on addressed or broadcast frames
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               hold_ff[ch] <= DDS_CODE_RST;
            end
            else if (frame_exec)
            begin
               case (mode)
                  dds_mode_hold_only, dds_mode_load_update:
                  begin
                     // only the addressed channel takes the code
                     if (sel_b == CH_B)
                     begin
                        hold_ff[ch] <= code;
                     end
                  end
                  dds_mode_both:
                  begin
                     hold_ff[ch] <= code;
                  end
                  default:
                  begin
                     // power-down keeps the held value
                     hold_ff[ch] <= hold_ff[ch];
                  end
               endcase
            end
         end

         // output register drives the converter code
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               out_ff[ch] <= DDS_CODE_RST; // zero volts
            end
            else if (frame_exec)
            begin
               case (mode)
                  dds_mode_load_update:
                  begin
                     // both outputs update, addressed one with new code
                     out_ff[ch] <= (sel_b == CH_B) ? code : hold_ff[ch];
                  end
                  dds_mode_both:
                  begin
                     out_ff[ch] <= code;
                  end
                  default:
                  begin
                     // hold-only and power-down leave the output alone
                     out_ff[ch] <= out_ff[ch];
                  end
               endcase
            end
         end
      end
   endgenerate

   assign channel_a_output_code = out_ff[0];
   assign channel_b_output_code = out_ff[1];

   // -------------------------------------------------------------------
   // power state
   // -------------------------------------------------------------------
   // mode 11 powers both down; any other frame wakes them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         powered_down_ff <= 1'b0;
         term_ff <= dds_term_high_z;
      end
      else if (frame_exec)
      begin
         if (mode == dds_mode_power_down)
         begin
            powered_down_ff <= 1'b1;
            term_ff <= nxt_term;
         end
         else
         begin
            powered_down_ff <= 1'b0;
         end
      end
   end

   assign powered_down = powered_down_ff;
   assign termination = term_ff;

   // -------------------------------------------------------------------
   // frame bookkeeping for software
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ever_valid_ff <= 1'b0;
         frame_cnt_ff <= '0;
         last_word_ff <= DDS_WORD_RST;
      end
      else if (frame_exec)
      begin
         ever_valid_ff <= 1'b1;
         frame_cnt_ff <= frame_cnt_ff + 1'b1;
         last_word_ff <= frame_word_ff;
      end
   end

   // -------------------------------------------------------------------
   // apb slave
   // -------------------------------------------------------------------
   // answer comes one cycle after setup: pready rises in the first
   // access cycle and falls the cycle after
   assign apb_setup = psel & ~penable & ~pready_ff;
   assign apb_wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;

   // read mux and address decode
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      nxt_err = 1'b0;
      case (paddr)
         DDS_OFF_CTRL: nxt_rdata[DDS_CTRL_ACCEPT] = accept_ff;
         DDS_OFF_STATUS:
         begin
            nxt_rdata[DDS_STAT_PD] = powered_down_ff;
            nxt_rdata[DDS_STAT_TERM_LO+1:DDS_STAT_TERM_LO] = term_ff;
            nxt_rdata[DDS_STAT_VALID] = ever_valid_ff;
         end
         DDS_OFF_OUT_A: nxt_rdata[DDS_CODE_W-1:0] = out_ff[0];
         DDS_OFF_OUT_B: nxt_rdata[DDS_CODE_W-1:0] = out_ff[1];
         DDS_OFF_HOLD_A: nxt_rdata[DDS_CODE_W-1:0] = hold_ff[0];
         DDS_OFF_HOLD_B: nxt_rdata[DDS_CODE_W-1:0] = hold_ff[1];
         DDS_OFF_FRAMES: nxt_rdata[FRAME_CNT_W-1:0] = frame_cnt_ff;
         DDS_OFF_LAST: nxt_rdata[DDS_WORD_W-1:0] = last_word_ff;
         default: nxt_err = 1'b1; // unmapped: error, data zero
      endcase
   end

   // handshake and read data registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else if (apb_setup)
      begin
         pready_ff <= 1'b1;
         pslverr_ff <= nxt_err;
         prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
      end
      else
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
   end

   // control register write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         accept_ff <= DDS_CTRL_ACCEPT_RST;
      end
      else if (apb_wr && paddr == DDS_OFF_CTRL)
      begin
         accept_ff <= pwdata[DDS_CTRL_ACCEPT];
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

endmodule

`default_nettype wire

// ---- hw/dds_pkg.sv ----
// Purpose: shared constants and types for the dual converter serial control
// Assumes: 32-bit APB register bus, one aligned word per register
// Notes: the command word is sixteen bits, sent most significant bit first
package dds_pkg;

   // ----------------------------------------------------------------------
   // command word layout
   // ----------------------------------------------------------------------
   localparam int unsigned DDS_WORD_W = 16; // bits in one command word
   localparam int unsigned DDS_CODE_W = 12; // bits of converter code
   localparam int unsigned DDS_BIT_LEAD_HIGH = 15; // lead_bit_high position
   localparam int unsigned DDS_BIT_LEAD_LOW = 14; // lead_bit_low / channel
   localparam int unsigned DDS_BIT_MODE_HIGH = 13; // mode_bit_high position
   localparam int unsigned DDS_BIT_MODE_LOW = 12; // mode_bit_low position
   localparam int unsigned DDS_CODE_MSB = 11; // top bit of the code field
   localparam logic [4:0] DDS_FRAME_LAST = 5'h0F; // index of sixteenth edge
   localparam logic [4:0] DDS_FRAME_DONE = 5'h10; // count after final bit
   localparam logic [4:0] DDS_CNT_RST = 5'h00; // bit count at frame start

   // ----------------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam int unsigned DDS_ADDR_W = 8;
   localparam logic [7:0] DDS_OFF_CTRL = 8'h00; // rw: frame accept enable
   localparam logic [7:0] DDS_OFF_STATUS = 8'h04; // ro: power state
   localparam logic [7:0] DDS_OFF_OUT_A = 8'h08; // ro: channel a output
   localparam logic [7:0] DDS_OFF_OUT_B = 8'h0C; // ro: channel b output
   localparam logic [7:0] DDS_OFF_HOLD_A = 8'h10; // ro: channel a holding
   localparam logic [7:0] DDS_OFF_HOLD_B = 8'h14; // ro: channel b holding
   localparam logic [7:0] DDS_OFF_FRAMES = 8'h18; // ro: frames executed
   localparam logic [7:0] DDS_OFF_LAST = 8'h1C; // ro: last command word

   // field positions and reset values
   localparam int unsigned DDS_CTRL_ACCEPT = 0; // ctrl: accept frames
   localparam int unsigned DDS_STAT_PD = 0; // status: powered down
   localparam int unsigned DDS_STAT_TERM_LO = 1; // status: termination lsb
   localparam int unsigned DDS_STAT_VALID = 3; // status: a frame executed
   localparam logic DDS_CTRL_ACCEPT_RST = 1'b1;
   localparam logic [11:0] DDS_CODE_RST = 12'h000; // zero volts at power-up
   localparam logic [15:0] DDS_WORD_RST = 16'h0000;

   // ----------------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------------
   // operating mode carried in the two mode bits
   typedef enum logic [1:0] {
      dds_mode_hold_only,   // load addressed holding register only
      dds_mode_load_update, // load addressed, update both outputs
      dds_mode_both,        // load both channels, update both outputs
      dds_mode_power_down   // power down both channels
   } dds_mode_t;

   // output termination while powered down
   typedef enum logic [1:0] {
      dds_term_high_z,   // outputs released, high impedance
      dds_term_2k5_gnd,  // 2.5 kilohm to ground
      dds_term_100k_gnd  // 100 kilohm to ground
   } dds_term_t;

endpackage

// ---- test/dds_host_model.sv ----
// Purpose: host side of the three-wire link, drives frames into the block
// Assumes: serial clock runs only inside a frame, 12 ns period
// Notes: strobe and data idle low between frames, strobe pulsed high first
`timescale 1ns/1ps
`default_nettype none

module dds_host_model
(
   output var logic serial_clk,
   output var logic frame_strobe_n,
   output var logic serial_data
);
   // idle: strobe high, clock parked high so no edge is pending
   initial
   begin
      serial_clk = 1'h1;
      frame_strobe_n = 1'h1;
      serial_data = 1'h0;
   end

   // ---------------------------------------------------------------
   // one frame: n bits of w msb first, then extra clocks of ones
   // ---------------------------------------------------------------
   task automatic send(input logic [15:0] w, input int n, input int extra);
      int i;
      begin
         // strobe high for a spell ends any earlier frame
         frame_strobe_n = 1'h1;
         #20;
         // strobe falls while the clock is high, away from a fall
         frame_strobe_n = 1'h0;
         for (i = 0; i < n + extra; i++)
         begin
            // bit set up before the falling edge that takes it
            serial_data = (i < n) ? w[15 - i] : 1'h1;
            #4 serial_clk = 1'h0;
            #6 serial_clk = 1'h1;
            #2;
         end
         // strobe and data left low until the next frame
         serial_data = 1'h0;
         #20;
      end
   endtask
endmodule

`default_nettype wire

// ---- test/dds_monitor.sv ----
// Purpose: concurrent checks on the converter control ports
// Assumes: frames executed reach the outputs within a few pclk cycles
// Notes: a toggle on the sixteenth serial fall times every change of the two channel codes and the power state
`timescale 1ns/1ps
`default_nettype none

module dds_monitor
#(
   parameter int unsigned FRAME_CNT_W = 16 // matches the top module
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dds_pkg::DDS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_clk,
   input wire logic frame_strobe_n,
   input wire logic serial_data,
   input wire logic [dds_pkg::DDS_CODE_W-1:0] channel_a_output_code,
   input wire logic [dds_pkg::DDS_CODE_W-1:0] channel_b_output_code,
   input wire logic powered_down,
   input wire logic [1:0] termination
);
   import dds_pkg::*;
   logic [4:0] edge_cnt_ff; // falls seen in this frame
   logic done_tgl_ff; // flips on each sixteenth fall
   logic [2:0] sync_ff; // toggle brought into pclk, third for the edge
   logic [4:0] age_ff; // pclk cycles since a frame completed

   // falls of the frame; a high strobe clears the count
   always_ff @(negedge serial_clk or posedge frame_strobe_n)
   begin
      if (frame_strobe_n)
         edge_cnt_ff <= DDS_CNT_RST;
      else if (edge_cnt_ff != DDS_FRAME_DONE)
         edge_cnt_ff <= edge_cnt_ff + 5'h01;
   end

   // completion toggle on the sixteenth fall only
   always_ff @(negedge serial_clk or negedge presetn)
   begin
      if (!presetn)
         done_tgl_ff <= 1'h0;
      else if (!frame_strobe_n && edge_cnt_ff == DDS_FRAME_LAST)
         done_tgl_ff <= ~done_tgl_ff;
   end

   // two-flop capture plus a third for the change, then the age
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_ff <= 3'h0;
      else
         sync_ff <= {sync_ff[1:0], done_tgl_ff};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         age_ff <= 5'h1F;
      else if (sync_ff[1] != sync_ff[2])
         age_ff <= 5'h00;
      else if (age_ff != 5'h1F)
         age_ff <= age_ff + 5'h01;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence

   AST_APB_ANSWER: assert property (s_setup |=> s_answer)
      else $error("apb answer not a one-cycle pulse after setup");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("slave error outside the answer cycle");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero outside the answer");
   AST_RESET_CLEAR: assert property ($rose(presetn) |->
      channel_a_output_code == DDS_CODE_RST &&
      channel_b_output_code == DDS_CODE_RST && !powered_down)
      else $error("outputs not cleared after reset");
   AST_PD_KEEPS_CODES: assert property ($rose(powered_down) |->
      $stable(channel_a_output_code) && $stable(channel_b_output_code))
      else $error("codes changed on power down");
   AST_TERM_LEGAL: assert property (termination != 2'h3)
      else $error("termination holds an unused value");
   AST_CODE_A_CAUSE: assert property (
      $changed(channel_a_output_code) |-> age_ff < 5'h06)
      else $error("channel a changed without a complete frame");
   AST_CODE_B_CAUSE: assert property (
      $changed(channel_b_output_code) |-> age_ff < 5'h06)
      else $error("channel b changed without a complete frame");
   AST_PD_CAUSE: assert property ($changed(powered_down) |->
      age_ff < 5'h06)
      else $error("power state changed without a complete frame");
endmodule

bind dds_top dds_monitor #(.FRAME_CNT_W(FRAME_CNT_W)) dds_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serial_clk(serial_clk),
   .frame_strobe_n(frame_strobe_n), .serial_data(serial_data),
   .channel_a_output_code(channel_a_output_code),
   .channel_b_output_code(channel_b_output_code),
   .powered_down(powered_down), .termination(termination));

`default_nettype wire

// ---- test/tb.sv ----
// Purpose: self-checking bench for the dual converter serial control
// Assumes: outputs settle within six pclk cycles of a frame's end
// Notes: apb reads check status, holding registers and frame count
`timescale 1ns/1ps
`default_nettype none

module tb;
   import dds_pkg::*;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, pd, sclk, strobe_n, sdata, err;
   logic [11:0] code_a, code_b;
   logic [1:0] term;
   int fail_count = 0;
   int tests_run = 0;
   int i;

   // 25 MHz bus clock
   always #20 pclk = ~pclk;

   dds_top dds_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_clk(sclk), .frame_strobe_n(strobe_n), .serial_data(sdata),
      .channel_a_output_code(code_a), .channel_b_output_code(code_b),
      .powered_down(pd), .termination(term));
   dds_host_model dds_host_model_i (.serial_clk(sclk),
      .frame_strobe_n(strobe_n), .serial_data(sdata));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] q, output logic e);
      int n;
      begin
         @(posedge pclk);
         psel <= 1'h1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'h1;
         n = 0;
         // answer and its data are taken at the rising edge only
         do
         begin
            @(posedge pclk);
            n++;
         end
         while (pready !== 1'h1 && n < 50);
         if (n == 50)
            fail_count++;
         q = prdata;
         e = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0, rd, err);
      chk(exp, rd);
      chk(32'h0, {31'h0, err});
   endtask

   task automatic chk_out(input logic [11:0] a, input logic [11:0] b,
      input logic p, input logic [1:0] t);
      chk({20'h0, a}, {20'h0, code_a});
      chk({20'h0, b}, {20'h0, code_b});
      chk({31'h0, p}, {31'h0, pd});
      chk({30'h0, t}, {30'h0, term});
   endtask

   // send a frame, then allow the crossing to land
   task automatic frame(input logic [15:0] w, input int n, input int x);
      dds_host_model_i.send(w, n, x);
      repeat (6) @(posedge pclk);
   endtask

   task final_report;
      $display("compares %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk_out(12'h000, 12'h000, 1'h0, 2'h0);
      rd_chk(DDS_OFF_CTRL, 32'h1);
      rd_chk(DDS_OFF_STATUS, 32'h0);
      apb(1'h0, 8'h40, 32'h0, rd, err);
      chk(32'h1, {31'h0, err});
      apb(1'h1, DDS_OFF_STATUS, 32'hF, rd, err);
      rd_chk(DDS_OFF_STATUS, 32'h0);
      frame(16'h1ABC, 16, 0);
      chk_out(12'hABC, 12'h000, 1'h0, 2'h0);
      frame(16'h4123, 16, 0);
      chk_out(12'hABC, 12'h000, 1'h0, 2'h0);
      rd_chk(DDS_OFF_HOLD_B, 32'h123);
      frame(16'h1001, 16, 0);
      chk_out(12'h001, 12'h123, 1'h0, 2'h0);
      frame(16'h2FFF, 10, 0);
      chk_out(12'h001, 12'h123, 1'h0, 2'h0);
      frame(16'h2800, 16, 4);
      chk_out(12'h800, 12'h800, 1'h0, 2'h0);
      for (i = 0; i < 4; i++)
      begin
         frame({i[1:0], 2'h3, 12'h000}, 16, 0);
         chk_out(12'h800, 12'h800, 1'h1, (i == 3) ? 2'h0 : i[1:0]);
      end
      rd_chk(DDS_OFF_STATUS, 32'h9);
      frame(16'h0FFF, 16, 0);
      chk_out(12'h800, 12'h800, 1'h0, 2'h0);
      rd_chk(DDS_OFF_HOLD_A, 32'hFFF);
      frame(16'h6FFF, 16, 0);
      chk_out(12'hFFF, 12'hFFF, 1'h0, 2'h0);
      apb(1'h1, DDS_OFF_CTRL, 32'h0, rd, err);
      frame(16'h2000, 16, 0);
      chk_out(12'hFFF, 12'hFFF, 1'h0, 2'h0);
      apb(1'h1, DDS_OFF_CTRL, 32'h1, rd, err);
      rd_chk(DDS_OFF_FRAMES, 32'hA);
      rd_chk(DDS_OFF_LAST, 32'h6FFF);
      final_report;
   end

   // watchdog far beyond the expected run time
   initial
   begin
      #400000;
      fail_count++;
      final_report;
   end
endmodule

`default_nettype wire
